/* verification/mdfm_bridge_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mdfm_bridge_model
    import mdfm_pkg::*;
(
    input  wire logic                    short_en,
    input  wire mdfm_pkg::mdfm_gate_type gate_out,
    output logic [5:0]                   drain_source_over
);
    // a shorted fet drops voltage only while its gate is on
    assign drain_source_over = short_en ? {gate_out.high, gate_out.low} : 6'h00;
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mdfm_pkg::*;
    logic clk = 0, rst_n = 0, idle = 0, short_en = 0, main_supply_low = 0, shunt_over = 0;
    logic gate_supply_low = 0, motor_lock_detect = 0, cycle_limit_over = 0, ipd_pulse_start = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [5:0] drain_source_over;
    mdfm_gate_type pwm_gate_cmd = 6'h21, gate_out;
    logic drive_pull_low, drive_disabled, charge_pump_en, logic_en, fault_out_n;
    int error_cnt = 0, compares = 0;
    always #2 clk = ~clk;
    mdfm_fault_manager #(.IPD_TIMEOUT_CYCLES(50), .LOCK_RETRY_CYCLES(20)) i_dut (.clk, .rst_n,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .main_supply_low, .regulator_low(idle),
        .gate_supply_low, .bootstrap_low({3{idle}}), .drain_source_over, .shunt_over,
        .thermal_over(idle), .motor_lock_detect, .cycle_limit_over,
        .lock_current_over(idle), .pwm_cycle_start(idle), .ipd_ramp_up(idle),
        .ipd_ramp_down(idle), .ipd_pulse_start, .ipd_current_decayed(idle),
        .pwm_gate_cmd, .gate_out, .drive_pull_low, .drive_disabled, .charge_pump_en,
        .logic_en, .drain_source_threshold_select(), .fault_out_n);
    mdfm_bridge_model i_bridge (.short_en, .gate_out, .drain_source_over);
    task print_verdict();
        if (error_cnt == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tick(input logic t);
        if (t) begin
            error_cnt++;
            print_verdict();
        end
        @(posedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ad, wd, ta, tw;
        n = 0; ad = 0; wd = 0;
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        while (!(ad && wd)) begin
            @(negedge clk);
            ta = !ad && s_axi_awready; tw = !wd && s_axi_wready;
            tick(++n > 50);
            if (ta) begin s_axi_awvalid <= 0; ad = 1; end
            if (tw) begin s_axi_wvalid <= 0; wd = 1; end
        end
        do begin @(negedge clk); tick(++n > 100); end while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask
    task rdx(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin @(negedge clk); tick(++n > 50); end while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do begin @(negedge clk); rd = s_axi_rdata; rs = s_axi_rresp; tick(++n > 100); end
        while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask
    task hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        hold(16);
        rst_n <= 1;
        hold(2);
        rdx(CONFIG_ADDR); chk("config", rd, CONFIG_RESET);
        rdx(8'h10); chk("unmapped", {30'h0, rs}, {30'h0, RESP_SLVERR});
        // a drop-out one cycle short of the deglitch must restart it
        shunt_over <= 1; hold(249); shunt_over <= 0; hold(6);
        chk("short glitch", {31'h0, fault_out_n}, 32'h1);
        shunt_over <= 1; hold(260);
        chk("shunt gates", {24'h0, gate_out, drive_pull_low, fault_out_n}, 32'h2);
        rdx(GATE_STATUS_ADDR); chk("gate status", rd & 32'h8, 32'h8);
        // clearing while still over current must be refused
        wr(CONTROL_ADDR, 32'h1); hold(4); chk("early clear", {31'h0, fault_out_n}, 32'h0);
        shunt_over <= 0; hold(2); wr(CONTROL_ADDR, 32'h1); hold(4);
        chk("shunt clear", {25'h0, gate_out, fault_out_n}, {25'h0, 6'h21, 1'b1});
        wr(CONFIG_ADDR, 32'h6); shunt_over <= 1; short_en <= 1; hold(300);
        chk("shunt off", {31'h0, fault_out_n}, 32'h1);
        rdx(GATE_STATUS_ADDR); chk("ds off", rd & 32'hC, 32'h0);
        shunt_over <= 0; wr(CONFIG_ADDR, 32'h0);
        short_en <= 1; hold(260);
        chk("ds gates", {24'h0, gate_out, drive_pull_low, fault_out_n}, 32'h2);
        short_en <= 0; hold(2); wr(CONTROL_ADDR, 32'h1); hold(4);
        chk("ds clear", {31'h0, fault_out_n}, 32'h1);
        gate_supply_low <= 1; hold(2600);
        chk("gate uv", {28'h0, drive_pull_low, charge_pump_en, logic_en, fault_out_n},
            32'hE);
        gate_supply_low <= 0; hold(4); chk("gate held", {31'h0, fault_out_n}, 32'h0);
        wr(CONTROL_ADDR, 32'h1); hold(4); chk("gate clear", {31'h0, fault_out_n}, 32'h1);
        wr(CONFIG_ADDR, 32'h2400); motor_lock_detect <= 1; hold(3);
        chk("lock", {30'h0, drive_pull_low, fault_out_n}, 32'h2);
        motor_lock_detect <= 0; hold(25); chk("lock retry", {31'h0, fault_out_n}, 32'h1);
        cycle_limit_over <= 1; hold(3);
        chk("cbc", {25'h0, gate_out, fault_out_n}, {25'h0, 6'h01, 1'b0});
        cycle_limit_over <= 0; hold(3);
        chk("cbc back", {25'h0, gate_out, fault_out_n}, {25'h0, 6'h21, 1'b1});
        ipd_pulse_start <= 1; hold(1); ipd_pulse_start <= 0; hold(3);
        chk("rate", {30'h0, drive_pull_low, fault_out_n}, 32'h2);
        wr(CONTROL_ADDR, 32'h1); hold(4); chk("rate clear", {31'h0, fault_out_n}, 32'h1);
        main_supply_low <= 1; hold(2600);
        chk("main uv", {28'h0, drive_disabled, charge_pump_en, logic_en, fault_out_n},
            32'h8);
        main_supply_low <= 0; hold(3);
        chk("main back", {28'h0, drive_disabled, charge_pump_en, logic_en, fault_out_n},
            32'h7);
        print_verdict();
    end
endmodule
`default_nettype wire

/* verilog/mdfm_fault_manager.sv */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - deglitched main supply undervoltage disables driver, pump, logic; fault pin low
// - main supply undervoltage recovers by itself when supply returns
// - deglitched regulator reset disables everything until level returns
// - gate supply undervoltage pulls gates low, pump keeps running, fault pin low
// - gate supply fault recovers only after condition ends and host clears
// - bootstrap undervoltage, when enabled, pulls gates low and latches until clear
// - drain-source overcurrent pulls gates low and latches until clear
// - drain-source detection ignored while its disable bit is one
// - shunt overcurrent flagged after comparator stays high past deglitch
// - shunt detection ignored while its disable bit is one
// - shunt overcurrent pulls gates low, latches until condition ends and clear
// - lock mode picks action; latched, timed retry, report only or nothing
// - cycle limit modes recirculate; even codes report; six reports; rest ignore
// - threshold cycle modes resume once current drops below limit
// - counted cycle modes resume after retry count plus one PWM cycles
// - lock current limit uses same action, latch, retry, report coding
// - position ramp lasting past 500 ms latches timeout fault, gates low
// - position pulse before previous decay latches rate fault, gates low
// - disabled driver uses weak pulldowns; pulled-low driver drives gates low
// - gate faults in gate status register, controller faults in controller status
// - thermal fault pulls gates low; auto bit picks latched or automatic recovery
module mdfm_fault_manager #(
    parameter int unsigned IPD_TIMEOUT_CYCLES = mdfm_pkg::IPD_TIMEOUT_MS * 1000
                                                * mdfm_pkg::CLK_MHZ,
    parameter int unsigned LOCK_RETRY_CYCLES  = mdfm_pkg::LOCK_RETRY_MS * 1000
                                                * mdfm_pkg::CLK_MHZ
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   main_supply_low,
    input  wire logic                   regulator_low,
    input  wire logic                   gate_supply_low,
    input  wire logic [2:0]             bootstrap_low,
    input  wire logic [5:0]             drain_source_over,
    input  wire logic                   shunt_over,
    input  wire logic                   thermal_over,
    input  wire logic                   motor_lock_detect,
    input  wire logic                   cycle_limit_over,
    input  wire logic                   lock_current_over,
    input  wire logic                   pwm_cycle_start,
    input  wire logic                   ipd_ramp_up,
    input  wire logic                   ipd_ramp_down,
    input  wire logic                   ipd_pulse_start,
    input  wire logic                   ipd_current_decayed,
    input  wire mdfm_pkg::mdfm_gate_type pwm_gate_cmd,
    output mdfm_pkg::mdfm_gate_type     gate_out,
    output logic                        drive_pull_low,
    output logic                        drive_disabled,
    output logic                        charge_pump_en,
    output logic                        logic_en,
    output logic [1:0]                  drain_source_threshold_select,
    output logic                        fault_out_n
);
    import mdfm_pkg::*;

    function automatic logic [12:0] dg_target(input int unsigned idx);
        int unsigned ns;
        int unsigned cyc;
        ns = (idx <= DG_BOOT) ? SUPPLY_DG_NS :
             (idx == DG_THERM) ? THERMAL_DG_NS :
             (idx == DG_LOCKI) ? LOCKCUR_DG_NS : OVERCUR_DG_NS;
        cyc = (ns * CLK_MHZ + 999) / 1000;
        return (cyc < 1) ? 13'h1 : cyc[12:0];
    endfunction

    function automatic mdfm_action_type worst(input mdfm_action_type a,
                                              input mdfm_action_type b);
        return (a > b) ? a : b;
    endfunction

    function automatic mdfm_action_type lock_action(input logic [3:0] mode);
        if (mode >= LOCK_REPORT_CODE) begin
            return ACT_DRIVE;
        end
        case (mode[1:0])
            2'h0: return ACT_PULL_LOW;
            2'h1: return ACT_RECIRC;
            2'h2: return ACT_HS_BRAKE;
            default: return ACT_LS_BRAKE;
        endcase
    endfunction

    mdfm_config_type      cfg;
    logic                 clear_pulse;
    logic [DG_COUNT-1:0]  raw;
    logic [DG_COUNT-1:0]  dg;
    logic [12:0]          dg_cnt [DG_COUNT];
    logic                 gate_flag, boot_flag, ds_flag, shunt_flag, therm_flag;
    logic [1:0]           lock_flag;
    logic [31:0]          lock_timer [2];
    logic [3:0]           lock_mode [2];
    logic [1:0]           lock_src;
    logic                 cbc_on;
    logic [8:0]           cbc_cnt;
    logic                 cbc_act, cbc_report;
    logic [31:0]          ipd_cnt;
    logic                 ipd_up_flag, ipd_down_flag, ipd_rate_flag;
    logic                 ipd_expired;
    logic [4:0]           gate_status;
    logic [5:0]           ctrl_status;
    logic                 any_report;
    mdfm_action_type      next_action;

    assign raw = {lock_current_over, thermal_over, shunt_over & ~cfg.shunt_fault_disable,
                  (|drain_source_over) & ~cfg.drain_source_fault_disable,
                  (|bootstrap_low) & ~cfg.bootstrap_fault_disable,
                  gate_supply_low, regulator_low, main_supply_low};

    for (genvar i = 0; i < DG_COUNT; i++) begin : g_dg
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                dg_cnt[i] <= 13'h0;
            end else if (!raw[i]) begin
                dg_cnt[i] <= 13'h0;
            end else if (dg_cnt[i] != dg_target(i)) begin
                dg_cnt[i] <= dg_cnt[i] + 13'h1;
            end
        end
        assign dg[i] = raw[i] && (dg_cnt[i] == dg_target(i));
    end

    // latched gate faults; a new set beats the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_flag  <= 1'b0;
            boot_flag  <= 1'b0;
            ds_flag    <= 1'b0;
            shunt_flag <= 1'b0;
        end else begin
            gate_flag  <= dg[DG_GATE]  | (gate_flag  & ~clear_pulse);
            boot_flag  <= dg[DG_BOOT]  | (boot_flag  & ~clear_pulse);
            ds_flag    <= dg[DG_DS]    | (ds_flag    & ~clear_pulse);
            shunt_flag <= dg[DG_SHUNT] | (shunt_flag & ~clear_pulse);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            therm_flag <= 1'b0;
        end else if (cfg.thermal_auto_recover) begin
            therm_flag <= dg[DG_THERM];
        end else begin
            therm_flag <= dg[DG_THERM] | (therm_flag & ~clear_pulse);
        end
    end

    assign lock_src  = {dg[DG_LOCKI], motor_lock_detect};
    assign lock_mode = '{cfg.lock_response_mode, cfg.lock_current_mode};

    // lock trips: latched, timed retry or report
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_flag     <= 2'b00;
            lock_timer[0] <= 32'h0;
            lock_timer[1] <= 32'h0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if (!lock_flag[k]) begin
                    lock_flag[k]  <= lock_src[k] && (lock_mode[k] <= LOCK_REPORT_CODE);
                    lock_timer[k] <= LOCK_RETRY_CYCLES;
                end else if (lock_mode[k][3:2] == 2'b01) begin
                    if (lock_timer[k] <= 32'h1) begin
                        lock_flag[k] <= 1'b0;
                    end else begin
                        lock_timer[k] <= lock_timer[k] - 32'h1;
                    end
                end else if (clear_pulse && !lock_src[k]) begin
                    lock_flag[k] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cbc_on  <= 1'b0;
            cbc_cnt <= 9'h0;
        end else if (!cbc_on) begin
            cbc_on  <= cycle_limit_over && (cfg.cycle_limit_mode <= CBC_REPORT_CODE);
            cbc_cnt <= 9'h0;
        end else begin
            case (cfg.cycle_limit_mode[3:1])
                3'h0: begin
                    if (pwm_cycle_start) begin
                        cbc_on <= 1'b0;
                    end
                end
                3'h1: begin
                    if (!cycle_limit_over) begin
                        cbc_on <= 1'b0;
                    end
                end
                3'h2: begin
                    if (pwm_cycle_start) begin
                        if (cbc_cnt == {1'b0, cfg.cycle_limit_retry_count}) begin
                            cbc_on <= 1'b0;
                        end else begin
                            cbc_cnt <= cbc_cnt + 9'h1;
                        end
                    end
                end
                3'h3: begin
                    if (!cfg.cycle_limit_mode[0] ? (clear_pulse && !cycle_limit_over)
                                                 : 1'b1) begin
                        cbc_on <= 1'b0;
                    end
                end
                default: begin
                    cbc_on <= 1'b0;
                end
            endcase
        end
    end

    assign cbc_act    = cbc_on && (cfg.cycle_limit_mode < CBC_REPORT_CODE);
    assign cbc_report = cbc_on && (cbc_act ? !cfg.cycle_limit_mode[0]
                                           : (cfg.cycle_limit_mode == CBC_REPORT_CODE));

    // ramp timeout counter restarts outside ramps
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ipd_cnt <= 32'h0;
        end else if (!(ipd_ramp_up || ipd_ramp_down)) begin
            ipd_cnt <= 32'h0;
        end else if (!ipd_expired) begin
            ipd_cnt <= ipd_cnt + 32'h1;
        end
    end
    assign ipd_expired = (ipd_cnt >= IPD_TIMEOUT_CYCLES);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ipd_up_flag   <= 1'b0;
            ipd_down_flag <= 1'b0;
            ipd_rate_flag <= 1'b0;
        end else begin
            ipd_up_flag   <= (ipd_expired && ipd_ramp_up) | (ipd_up_flag & ~clear_pulse);
            ipd_down_flag <= (ipd_expired && ipd_ramp_down)
                             | (ipd_down_flag & ~clear_pulse);
            ipd_rate_flag <= (ipd_pulse_start && !ipd_current_decayed)
                             | (ipd_rate_flag & ~clear_pulse);
        end
    end

    assign gate_status = {therm_flag, shunt_flag, ds_flag, boot_flag, gate_flag};
    assign ctrl_status = {ipd_rate_flag, ipd_down_flag, ipd_up_flag,
                          lock_flag[1], cbc_on, lock_flag[0]};

    always_comb begin
        next_action = ACT_DRIVE;
        if (cbc_act) begin
            next_action = ACT_RECIRC;
        end
        for (int k = 0; k < 2; k++) begin
            if (lock_flag[k]) begin
                next_action = worst(next_action, lock_action(lock_mode[k]));
            end
        end
        if (|{gate_status, ipd_up_flag, ipd_down_flag, ipd_rate_flag}) begin
            next_action = ACT_PULL_LOW;
        end
        if (dg[DG_MAIN] || dg[DG_REG]) begin
            next_action = ACT_DISABLE;
        end
    end

    assign any_report = dg[DG_MAIN] || dg[DG_REG] || (|gate_status) || cbc_report
                        || (|lock_flag) || ipd_up_flag || ipd_down_flag || ipd_rate_flag;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_out       <= '0;
            drive_pull_low <= 1'b1;
            drive_disabled <= 1'b0;
            charge_pump_en <= 1'b0;
            logic_en       <= 1'b0;
            fault_out_n    <= 1'b1;
        end else begin
            drive_pull_low <= (next_action == ACT_PULL_LOW);
            drive_disabled <= (next_action == ACT_DISABLE);
            charge_pump_en <= (next_action != ACT_DISABLE);
            logic_en       <= (next_action != ACT_DISABLE);
            fault_out_n    <= !any_report;
            case (next_action)
                ACT_DRIVE:    gate_out <= pwm_gate_cmd;
                ACT_RECIRC:   gate_out <= '{high: '0, low: pwm_gate_cmd.low};
                ACT_HS_BRAKE: gate_out <= '{high: '1, low: '0};
                ACT_LS_BRAKE: gate_out <= '{high: '0, low: '1};
                default:      gate_out <= '0;
            endcase
        end
    end

    // AXI4-Lite slave; one write and one read outstanding
    logic        aw_held, w_held;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q, strb_mask;
    logic [3:0]  w_strb_q;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign drain_source_threshold_select = cfg.drain_source_threshold_select;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_data_q     <= 32'h0000_0000;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            cfg          <= CONFIG_RESET;
            clear_pulse  <= 1'b0;
        end else begin
            clear_pulse <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held   <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held   <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                case (aw_addr_q)
                    CONTROL_ADDR:
                        clear_pulse <= w_strb_q[0] && w_data_q[CLEAR_FAULT_POS];
                    CONFIG_ADDR:
                        cfg <= (cfg & ~(strb_mask & CONFIG_WMASK))
                               | (w_data_q & strb_mask & CONFIG_WMASK);
                    GATE_STATUS_ADDR, CTRL_STATUS_ADDR: ;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                CONTROL_ADDR:     s_axi_rdata <= 32'h0000_0000;
                CONFIG_ADDR:      s_axi_rdata <= cfg;
                GATE_STATUS_ADDR: s_axi_rdata <= {27'h0, gate_status};
                CTRL_STATUS_ADDR: s_axi_rdata <= {26'h0, ctrl_status};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_main_uv_off: assert property (dg[DG_MAIN] |=> !logic_en && !charge_pump_en
                                    && drive_disabled && !fault_out_n)
        else $error("main supply fault did not disable the driver");
    a_main_uv_back: assert property ($fell(dg[DG_MAIN]) && !dg[DG_REG] && !any_report
                                     |=> logic_en && fault_out_n)
        else $error("main supply fault did not recover by itself");
    a_regulator_off: assert property (dg[DG_REG] |=> !logic_en && gate_out == '0)
        else $error("regulator fault did not disable the driver");
    a_gate_uv_pump: assert property (gate_flag && !dg[DG_MAIN] && !dg[DG_REG]
                                     |=> charge_pump_en && drive_pull_low && gate_out == '0)
        else $error("gate supply fault action wrong");
    a_gate_uv_hold: assert property (gate_flag && !clear_pulse |=> gate_flag)
        else $error("gate supply fault released without clear");
    a_ds_ignored: assert property (cfg.drain_source_fault_disable && !ds_flag
                                   |=> !ds_flag)
        else $error("drain-source fault raised while disabled");
    a_shunt_ignored: assert property (cfg.shunt_fault_disable && !shunt_flag
                                      |=> !shunt_flag)
        else $error("shunt fault raised while disabled");
    a_deglitch_restart: assert property (!raw[DG_SHUNT] |=> dg_cnt[DG_SHUNT] == 13'h0)
        else $error("deglitch counter did not restart");
    a_rate_fault_set: assert property (ipd_pulse_start && !ipd_current_decayed
                                       |=> ipd_rate_flag ##1 !fault_out_n)
        else $error("position rate fault not raised");
    a_cbc_threshold: assert property (cbc_on && cfg.cycle_limit_mode[3:1] == 3'h1
                                      && !cycle_limit_over |=> !cbc_on)
        else $error("threshold cycle limit did not release");
    a_fault_pin: assert property (any_report |=> !fault_out_n)
        else $error("fault pin not asserted for reporting fault");

endmodule

`default_nettype wire

/* verilog/mdfm_pkg.sv */
`default_nettype none
package mdfm_pkg;

    localparam int unsigned PHASES = 3;
    localparam int unsigned CLK_MHZ = 250;

    // register byte addresses
    localparam logic [7:0] CONTROL_ADDR     = 8'h00;
    localparam logic [7:0] CONFIG_ADDR      = 8'h04;
    localparam logic [7:0] GATE_STATUS_ADDR = 8'h08;
    localparam logic [7:0] CTRL_STATUS_ADDR = 8'h0C;

    localparam int unsigned CLEAR_FAULT_POS = 0;
    localparam logic [31:0] CONFIG_RESET    = 32'h0000_0000;
    localparam logic [31:0] CONFIG_WMASK    = 32'h0FFF_FF3F;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // deglitch times in ns and the two long timers
    localparam int unsigned SUPPLY_DG_NS   = 10000;
    localparam int unsigned OVERCUR_DG_NS  = 1000;
    localparam int unsigned THERMAL_DG_NS  = 10000;
    localparam int unsigned LOCKCUR_DG_NS  = 1000;
    localparam int unsigned IPD_TIMEOUT_MS = 500;
    localparam int unsigned LOCK_RETRY_MS  = 1000;

    localparam logic [3:0] LOCK_REPORT_CODE = 4'h8;
    localparam logic [3:0] CBC_REPORT_CODE  = 4'h6;

    // deglitched condition indices
    localparam int unsigned DG_MAIN  = 0;
    localparam int unsigned DG_REG   = 1;
    localparam int unsigned DG_GATE  = 2;
    localparam int unsigned DG_BOOT  = 3;
    localparam int unsigned DG_DS    = 4;
    localparam int unsigned DG_SHUNT = 5;
    localparam int unsigned DG_THERM = 6;
    localparam int unsigned DG_LOCKI = 7;
    localparam int unsigned DG_COUNT = 8;

    typedef struct packed {
        logic [PHASES-1:0] high;
        logic [PHASES-1:0] low;
    } mdfm_gate_type;

    typedef struct packed {
        logic [3:0] reserved_hi;
        logic [7:0] cycle_limit_retry_count;
        logic [3:0] lock_current_mode;
        logic [3:0] cycle_limit_mode;
        logic [3:0] lock_response_mode;
        logic [1:0] reserved_lo;
        logic [1:0] drain_source_threshold_select;
        logic       thermal_auto_recover;
        logic       shunt_fault_disable;
        logic       drain_source_fault_disable;
        logic       bootstrap_fault_disable;
    } mdfm_config_type;

    typedef enum logic [2:0] {
        ACT_DRIVE,
        ACT_RECIRC,
        ACT_HS_BRAKE,
        ACT_LS_BRAKE,
        ACT_PULL_LOW,
        ACT_DISABLE
    } mdfm_action_type;

endpackage

`default_nettype wire
